// >>> common/nvmrd_params.svh
// constants for the nonvolatile byte read port
`ifndef NVMRD_PARAMS_SVH
`define NVMRD_PARAMS_SVH
`define NVMRD_BANKS 8
`define NVMRD_BANK_BITS 128
`define NVMRD_BYTES_PER_BANK 16
`define NVMRD_BANK_SEL_W 3
`define NVMRD_BYTE_SEL_W 4
`define NVMRD_ADDR_W 7
`define NVMRD_DATA_W 8
`define NVMRD_BANK_MSB 6
`define NVMRD_BANK_LSB 4
`define NVMRD_BYTE_MSB 3
`define NVMRD_BYTE_LSB 0
`define NVMRD_ERASED_BANK 128'hffffffffffffffffffffffffffffffff
`define NVMRD_ERASE_CYCLES 16
`define NVMRD_WRITE_CYCLES 16
`define NVMRD_CNT_W 12
`endif

// >>> common/nvmrd_pkg.sv
// types for the nonvolatile byte read port
package nvmrd_pkg;
  typedef enum logic [2:0] {
    NVMRD_IDLE = 3'b001,
    NVMRD_ERASE = 3'b010,
    NVMRD_WRITE = 3'b100
  } nvmrd_state_t;
endpackage : nvmrd_pkg

// >>> design/nvmrd_top.sv
// nonvolatile byte read port with bank-wise programming
`timescale 1ns/1ns
`include "nvmrd_params.svh"
// Function
// - storage is 1 kbit held as eight separate banks of 128 bits each.
// - on read-back each bank appears as sixteen individually addressed bytes.
// - only the scan programming port can write; the fabric port has no write path.
// - programming rewrites any chosen bank, always one whole bank at a time.
// - a bank is erased automatically before new contents are written into it.
// - the read port is synchronous to the access clock and returns single bytes.
// - the top three address bits select one of the eight banks.
// - the low four address bits select one of the sixteen bytes of that bank.
// - an address taken at a rising edge gives valid data at the next falling edge.
// - with a steady address data goes invalid at each rising edge, valid at each falling.
module nvmrd_top #(
  parameter int ERASE_CYCLES = `NVMRD_ERASE_CYCLES,
  parameter int WRITE_CYCLES = `NVMRD_WRITE_CYCLES,
  parameter logic [`NVMRD_BANKS*`NVMRD_BANK_BITS-1:0] INIT_CONTENT =
    {`NVMRD_BANKS{`NVMRD_ERASED_BANK}}
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [`NVMRD_ADDR_W-1:0] RD_ADDR_I,
  output logic [`NVMRD_DATA_W-1:0] RD_DATA_O,
  output logic RD_VALID_O,
  input wire logic PROG_REQ_I,
  input wire logic [`NVMRD_BANK_SEL_W-1:0] PROG_BANK_I,
  input wire logic [`NVMRD_BANK_BITS-1:0] PROG_DATA_I,
  output logic PROG_BUSY_O,
  output logic PROG_DONE_O
);
  import nvmrd_pkg::*;

  logic [`NVMRD_BANK_BITS-1:0] bank_q [`NVMRD_BANKS];
  logic [`NVMRD_ADDR_W-1:0] addr_q;
  logic [`NVMRD_DATA_W-1:0] dout_q;
  logic rise_tgl_q;
  logic fall_tgl_q;
  logic req_m_q, req_s_q, req_d_q;
  logic [`NVMRD_BANK_SEL_W-1:0] pbank_m_q, pbank_s_q, pbank_q;
  logic [`NVMRD_BANK_BITS-1:0] pdata_m_q, pdata_s_q, pdata_q;
  nvmrd_state_t state_q, state_d;
  logic [`NVMRD_CNT_W-1:0] cnt_q;
  logic done_q;

  // read decode, fabric side is read-only
  wire [`NVMRD_BANK_SEL_W-1:0] rd_bank = addr_q[`NVMRD_BANK_MSB:`NVMRD_BANK_LSB];
  wire [`NVMRD_BYTE_SEL_W-1:0] rd_byte = addr_q[`NVMRD_BYTE_MSB:`NVMRD_BYTE_LSB];
  wire [`NVMRD_BANK_BITS-1:0] rd_word = bank_q[rd_bank];
  wire [`NVMRD_DATA_W-1:0] rd_sel = rd_word[{rd_byte, 3'b000} +: `NVMRD_DATA_W];

  // address taken on the rising edge
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      addr_q <= '0;
      rise_tgl_q <= 1'b0;
    end else begin
      addr_q <= RD_ADDR_I;
      rise_tgl_q <= ~rise_tgl_q;
    end
  end

  // data launched on the falling edge so it is stable before the next rise
  always_ff @(negedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dout_q <= '0;
      fall_tgl_q <= 1'b0;
    end else begin
      dout_q <= rd_sel;
      fall_tgl_q <= rise_tgl_q;
    end
  end

  assign RD_DATA_O = dout_q;
  assign RD_VALID_O = (rise_tgl_q == fall_tgl_q);

  // programming pins come from the scan domain
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_d_q <= 1'b0;
      pbank_m_q <= '0;
      pbank_s_q <= '0;
      pdata_m_q <= '0;
      pdata_s_q <= '0;
    end else begin
      req_m_q <= PROG_REQ_I;
      req_s_q <= req_m_q;
      req_d_q <= req_s_q;
      pbank_m_q <= PROG_BANK_I;
      pbank_s_q <= pbank_m_q;
      pdata_m_q <= PROG_DATA_I;
      pdata_s_q <= pdata_m_q;
    end
  end

  wire req_rise = req_s_q & ~req_d_q;
  wire start = req_rise && (state_q == NVMRD_IDLE);
  wire erase_end = (state_q == NVMRD_ERASE) && (cnt_q == `NVMRD_CNT_W'(ERASE_CYCLES - 1));
  wire write_end = (state_q == NVMRD_WRITE) && (cnt_q == `NVMRD_CNT_W'(WRITE_CYCLES - 1));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      NVMRD_IDLE: if (start) state_d = NVMRD_ERASE;
      NVMRD_ERASE: if (erase_end) state_d = NVMRD_WRITE;
      NVMRD_WRITE: if (write_end) state_d = NVMRD_IDLE;
      default: state_d = NVMRD_IDLE;
    endcase
  end

  // bank and data held for the whole sequence; a request edge seen while not idle is dropped
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= NVMRD_IDLE;
      cnt_q <= '0;
      pbank_q <= '0;
      pdata_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
      done_q <= write_end;
      if (start) begin
        pbank_q <= pbank_s_q;
        pdata_q <= pdata_s_q;
      end
    end
  end

  assign PROG_BUSY_O = (state_q != NVMRD_IDLE);
  assign PROG_DONE_O = done_q;

  // storage, one whole bank changes at a time
  for (genvar b = 0; b < `NVMRD_BANKS; b++) begin : g_bank
    wire sel = (pbank_q == `NVMRD_BANK_SEL_W'(b));
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        // reset stands in for contents retained across power
        bank_q[b] <= INIT_CONTENT[b*`NVMRD_BANK_BITS +: `NVMRD_BANK_BITS];
      end else if (sel && erase_end) begin
        bank_q[b] <= `NVMRD_ERASED_BANK;
      end else if (sel && write_end) begin
        bank_q[b] <= pdata_q;
      end
    end
  end
endmodule : nvmrd_top

// >>> bench/nvmrd_props.sv
// read port checker
`timescale 1ns/1ns
module nvmrd_chk (
  input logic CORE_CLK_I, RST_I, RD_VALID_O, PROG_REQ_I, PROG_BUSY_O, PROG_DONE_O,
  input logic [6:0] RD_ADDR_I,
  input logic [7:0] RD_DATA_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  AST_VLD: assert property (RD_VALID_O) else $error("vld");
  AST_HOLD: assert property (!$past(RST_I) && $stable(RD_ADDR_I) && !PROG_BUSY_O
    |=> $stable(RD_DATA_O)) else $error("hold");
  AST_ONE: assert property (PROG_DONE_O |=> !PROG_DONE_O) else $error("one");
  AST_END: assert property ($fell(PROG_BUSY_O) |-> PROG_DONE_O) else $error("end");
  AST_WHY: assert property (PROG_DONE_O |-> $past(PROG_BUSY_O)) else $error("why");
  AST_EXC: assert property (PROG_BUSY_O |-> !PROG_DONE_O) else $error("exc");
  AST_REQ: assert property ($rose(PROG_BUSY_O) |-> $past(PROG_REQ_I)) else $error("req");
  AST_LEN: assert property ($rose(PROG_BUSY_O) |-> PROG_BUSY_O[*4]) else $error("len");
endmodule : nvmrd_chk
bind nvmrd_top nvmrd_chk u_nvmrd_chk (.*);

// >>> bench/nvmrd_reader.sv
// fabric reader model
`timescale 1ns/1ns
module nvmrd_reader (
  input logic clk_i,
  input logic [7:0] data_i,
  output logic [7:0] got_o
);
  // midway through the low half, clear of the next rise
  always @(negedge clk_i) begin
    #5 got_o = data_i;
  end
endmodule : nvmrd_reader

// >>> bench/testbench.sv
// read port bench
`timescale 1ns/1ns
module testbench;
  logic clk = 0, rst = 1, req = 0, vld, done, busy;
  logic [6:0] addr = '0;
  logic [7:0] data, got;
  int n_mismatch = 0, samples_checked = 0;
  function automatic logic [1023:0] pat();
    for (int i = 0; i < 128; i++) pat[i*8+:8] = 8'(i*3+1);
  endfunction : pat
  nvmrd_top #(.ERASE_CYCLES(2), .WRITE_CYCLES(2), .INIT_CONTENT(pat())) u_nvmrd_top (
    .CORE_CLK_I(clk), .RST_I(rst), .RD_ADDR_I(addr), .RD_DATA_O(data), .RD_VALID_O(vld),
    .PROG_REQ_I(req), .PROG_BANK_I(3'h5), .PROG_DATA_I(128'h5a), .PROG_BUSY_O(busy),
    .PROG_DONE_O(done));
  nvmrd_reader u_nvmrd_reader (.clk_i(clk), .data_i(data), .got_o(got));
  initial forever #10 clk = ~clk;
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s %h %h", s, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("%0d checks %0d bad", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // steady address over two rises
  task automatic t_read(logic [1023:0] m);
    for (int a = 0; a < 128; a++) begin
      addr = 7'(a);
      @(posedge clk) #1;
      repeat (2) begin
        chk("vld", 8'h0, {7'h0, vld});
        @(negedge clk) #6;
        chk("vld_fall", 8'h1, {7'h0, vld});
        chk("byte", m[a*8+:8], got);
        @(posedge clk) #1;
      end
    end
  endtask : t_read
  task automatic t_prog();
    logic [1023:0] m = pat();
    logic seen_busy = 1'b0;
    m[640+:128] = 128'h5a;
    req = 1;
    for (int i = 0; i < 20 && done !== 1'b1; i++) begin
      @(posedge clk) #1;
      if (busy === 1'b1) seen_busy = 1'b1;
    end
    chk("done", 8'h1, {7'h0, done});
    chk("busy_seen", 8'h1, {7'h0, seen_busy});
    chk("busy_end", 8'h0, {7'h0, busy});
    if (done === 1'b1) begin
      req = 0;
      t_read(m);
    end
  endtask : t_prog
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    t_prog();
    wrap_up();
  end
endmodule : testbench
